/* File: fastening_io_status_logic_tb_top.sv */
// Self-checking testbench of the I/O status block
`timescale 1ns/1ns
`default_nettype none
`include "fios_map.svh"
module fastening_io_status_logic_tb_top;
   localparam int HOLD = 20;
   localparam int B_ALL = 13, B_PT = 12, B_CAP = 11, B_COM = 10;
   localparam int B_ZERO = 9, B_START = 8, B_RES = 7, B_RST = 6;

   logic                  clock = 1'b0;
   logic                  sys_rst = 1'b1;
   fios_pkg::fios_pins_s  pins;
   fios_pkg::fios_core_s  core = '0;
   logic [7:0]            bus_addr = 8'h00;
   logic [31:0]           bus_wdata = 32'h00000000;
   logic                  bus_wr = 1'b0;
   logic                  bus_rd = 1'b0;
   logic [31:0]           bus_rdata;
   fios_pkg::fios_stat_s  stat;
   fios_pkg::fios_teach_e teach_mode;
   fios_pkg::fios_xy_s    origin_xy;
   logic                  irq;
   int                    n_fail = 0;
   int                    total_checks = 0;
   int                    cycles = 0;

   always #5 clock = ~clock;

   fios_top #(.CYC_PER_MS(10), .IN_HOLD_CYC(HOLD)) dut (
      .clock(clock), .sys_rst(sys_rst), .pins(pins), .core(core),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .stat(stat), .teach_mode(teach_mode),
      .origin_xy(origin_xy), .irq(irq));

   fios_plc_model #(.HOLD_CYC(HOLD)) plc (.clock(clock), .ready(stat.ready), .pins(pins));

   // ************************************************************
   // Access and check tasks
   // ************************************************************
   task automatic results;
      if (n_fail == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
   endtask

   task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      #1;
      chk(nm, exp, bus_rdata);
   endtask

   task automatic endcyc(input logic ok, input logic batch);
      @(posedge clock);
      if (batch) begin
         core.batch_done <= 1'b1;
         core.batch_ok <= ok;
      end else begin
         core.cycle_end <= 1'b1;
         core.cycle_ok <= ok;
         core.cycle_active <= 1'b0;
      end
      @(posedge clock);
      core.cycle_end <= 1'b0;
      core.batch_done <= 1'b0;
      wt(2);
   endtask

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_fail++;
         results;
      end
   end

   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      core.channel_valid = 1'b1;
      core.trace_job_en = 1'b1;
      repeat (12) @(posedge clock);
      sys_rst <= 1'b0;
      wt(3);
      chk("stat", 8'h80, stat);
      chk("teach_mode", fios_pkg::T_IDLE, teach_mode);
      chk("origin", 32'h00000000, origin_xy);
      chk("irq", 1'b0, irq);
      rdchk("ctrl", `FIOS_OFS_CTRL, 32'h00640000);
      wr(`FIOS_OFS_LIST_IDX, 32'h00000001);
      rdchk("list_idx", `FIOS_OFS_LIST_IDX, 32'h00000001);
      rdchk("unmapped", 8'hFC, 32'h00000000);
      // Teach-point refused while rotating, then accepted
      @(posedge clock);
      core.tool_rotating <= 1'b1;
      plc.sel(6'h05);
      plc.level(B_PT, 1'b1);
      wt(6);
      chk("teach_mode", fios_pkg::T_IDLE, teach_mode);
      @(posedge clock);
      core.tool_rotating <= 1'b0;
      core.panel_active <= 1'b1;
      wt(6);
      chk("teach_mode", fios_pkg::T_IDLE, teach_mode);
      plc.level(B_PT, 1'b0);
      wt(6);
      @(posedge clock);
      core.panel_active <= 1'b0;
      core.arm_xy <= 32'h1234ABCD;
      wt(6);
      plc.level(B_PT, 1'b1);
      wt(6);
      chk("teach_mode", fios_pkg::T_POINT, teach_mode);
      rdchk("state", `FIOS_OFS_STATE, 32'h00000280);
      plc.pulse(B_CAP);
      plc.pulse(B_COM);
      wr(`FIOS_OFS_MASK, 32'h00000008);
      wt(3);
      chk("irq", 1'b1, irq);
      rdchk("status", `FIOS_OFS_STATUS, 32'h00000008);
      wt(2);
      chk("irq", 1'b0, irq);
      wr(`FIOS_OFS_LIST_IDX, 32'h00000005);
      rdchk("list_idx", `FIOS_OFS_LIST_IDX, 32'h80000005);
      rdchk("list_xy", `FIOS_OFS_LIST_XY, 32'h1234ABCD);
      // Capture, leave without commit, commit later: entry stays invalid
      plc.level(B_PT, 1'b0);
      plc.sel(6'h06);
      wt(6);
      plc.level(B_PT, 1'b1);
      wt(6);
      plc.pulse(B_CAP);
      plc.level(B_PT, 1'b0);
      wt(6);
      plc.level(B_PT, 1'b1);
      wt(6);
      plc.pulse(B_COM);
      plc.level(B_PT, 1'b0);
      wr(`FIOS_OFS_LIST_IDX, 32'h00000006);
      rdchk("list_idx", `FIOS_OFS_LIST_IDX, 32'h00000006);
      plc.level(B_ALL, 1'b1);
      wt(6);
      chk("teach_mode", fios_pkg::T_ALL, teach_mode);
      // Two captures walk entries 1 and 2, commit keeps both
      plc.pulse(B_CAP);
      plc.pulse(B_CAP);
      plc.pulse(B_COM);
      plc.level(B_ALL, 1'b0);
      wt(6);
      chk("teach_mode", fios_pkg::T_IDLE, teach_mode);
      wr(`FIOS_OFS_LIST_IDX, 32'h00000002);
      rdchk("list_idx", `FIOS_OFS_LIST_IDX, 32'h80000002);
      rdchk("list_xy", `FIOS_OFS_LIST_XY, 32'h1234ABCD);
      wr(`FIOS_OFS_LIST_IDX, 32'h00000003);
      rdchk("list_idx", `FIOS_OFS_LIST_IDX, 32'h00000003);
      // Origin set, then lost backup
      @(posedge clock);
      core.arm_xy <= 32'h00100020;
      plc.pulse(B_ZERO);
      chk("origin", 32'h00100020, origin_xy);
      rdchk("origin_reg", `FIOS_OFS_ORIGIN, 32'h00100020);
      @(posedge clock);
      core.battery_lost <= 1'b1;
      wt(3);
      chk("origin", 32'h00000000, origin_xy);
      @(posedge clock);
      core.battery_lost <= 1'b0;
      core.cycle_active <= 1'b1;
      wt(3);
      chk("stat", 8'hC0, stat);
      endcyc(1'b1, 1'b0);
      chk("stat", 8'h98, stat);
      plc.pulse(B_START);
      chk("stat", 8'h80, stat);
      endcyc(1'b0, 1'b0);
      chk("stat", 8'h94, stat);
      endcyc(1'b0, 1'b1);
      chk("stat", 8'h95, stat);
      // Held style outlives the pulse length
      wt(1010);
      chk("stat", 8'h95, stat);
      plc.pulse(B_RST);
      chk("stat", 8'h80, stat);
      endcyc(1'b1, 1'b1);
      chk("stat", 8'h82, stat);
      plc.pulse(B_RES);
      chk("stat", 8'h80, stat);
      // Fault in mid-cycle
      @(posedge clock);
      core.cycle_active <= 1'b1;
      @(posedge clock);
      core.fault_event <= 1'b1;
      @(posedge clock);
      core.fault_event <= 1'b0;
      wt(2);
      chk("stat", 8'h70, stat);
      @(posedge clock);
      core.cycle_active <= 1'b0;
      wt(20);
      chk("stat", 8'h30, stat);
      plc.pulse(B_RES);
      chk("stat", 8'h80, stat);
      // Pulse style, 3 ms of 10 cycles
      wr(`FIOS_OFS_CTRL, 32'h00030001);
      @(posedge clock);
      core.cycle_active <= 1'b1;
      wt(2);
      endcyc(1'b1, 1'b0);
      chk("stat", 8'h98, stat);
      wt(24);
      chk("stat", 8'h98, stat);
      wt(10);
      chk("stat", 8'h90, stat);
      @(posedge clock);
      core.channel_valid <= 1'b0;
      wt(3);
      chk("stat", 8'h10, stat);
      results;
   end
endmodule // fastening_io_status_logic_tb_top
`default_nettype wire

/* File: fios_in_qual.sv */
// Pin synchroniser and minimum-hold pulse qualifier
`timescale 1ns/1ns
`default_nettype none
module fios_in_qual #(
   parameter int WIDTH    = 14,
   parameter int HOLD_CYC = 10000001
) (
   input  wire logic             clock,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] pulse
);
   localparam int CW = $clog2(HOLD_CYC + 1);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [CW-1:0]    cnt_reg [WIDTH];

   if (WIDTH < 1 || HOLD_CYC < 2) begin : g_chk
      $error("fios_in_qual: bad parameters");
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= pin_in;
         sync_reg <= meta_reg;
      end
   end

   // One pulse per assertion once held past the minimum time
   always_ff @(posedge clock) begin
      for (int i = 0; i < WIDTH; i++) begin
         if (sys_rst || !sync_reg[i]) begin
            cnt_reg[i] <= '0;
            pulse[i]   <= 1'b0;
         end else begin
            if (cnt_reg[i] != CW'(HOLD_CYC)) begin
               cnt_reg[i] <= cnt_reg[i] + CW'(1);
            end
            pulse[i] <= (cnt_reg[i] == CW'(HOLD_CYC - 1));
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         level <= '0;
      end else begin
         level <= sync_reg;
      end
   end
endmodule // fios_in_qual
`default_nettype wire

/* File: fios_map.svh */
// Offsets, field positions, reset values and timing figures of the I/O status block
// Overview of operation
// - Teach-all held: stay in all-position teaching
// - Teach-point held: teach only selected position
// - Teach-point refused while rotating or panel busy
// - Capture stores arm coordinates into selected entry
// - Commit validates pending; exit without commit discards
// - Zero-set takes arm origin; lost backup clears
// - Position select six-bit binary; zero invalid
// - Ready unless fault or no valid selection
// - Busy exactly during fastening cycle
// - Fault held until resume or reset input
// - Cycle-done on finish, also fault-terminated
// - One of pass/fail per cycle, cleared
// - Batch pass/fail on verdict, same clearing
// - Style selects held level or pulse pass/fail outputs (cycle/batch judgement only)
`ifndef FIOS_MAP_SVH
`define FIOS_MAP_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define FIOS_OFS_CTRL      8'h00
`define FIOS_OFS_STATUS    8'h04
`define FIOS_OFS_MASK      8'h08
`define FIOS_OFS_STATE     8'h0C
`define FIOS_OFS_LIST_IDX  8'h10
`define FIOS_OFS_LIST_XY   8'h14
`define FIOS_OFS_ORIGIN    8'h18

// ************************************************************
// Fields and reset values
// ************************************************************
`define FIOS_CTRL_STYLE_BIT  0
`define FIOS_CTRL_MS_LSB     16
`define FIOS_CTRL_MS_MSB     31
`define FIOS_RST_PULSE_MS    16'h0064
`define FIOS_RST_MASK        4'h0
`define FIOS_EV_FAULT        0
`define FIOS_EV_CYCLE        1
`define FIOS_EV_BATCH        2
`define FIOS_EV_COMMIT       3
`define FIOS_EV_W            4

// ************************************************************
// Timing
// ************************************************************
`define FIOS_CLK_HZ          100000000
`define FIOS_IN_HOLD_MS      100
`define FIOS_MS_DIV          1000

`endif

/* File: fios_pkg.sv */
// Types shared by the I/O status block
package fios_pkg;
   typedef enum logic [1:0] {T_IDLE, T_ALL, T_POINT} fios_teach_e;
   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
   } fios_xy_s;
   typedef struct packed {
      logic       teach_all;
      logic       teach_point;
      logic       capture;
      logic       commit;
      logic       zero_set;
      logic       start;
      logic       resume;
      logic       reset_in;
      logic [5:0] pos_sel;
   } fios_pins_s;
   typedef struct packed {
      logic     trace_job_en;
      logic     tool_rotating;
      logic     panel_active;
      logic     cycle_active;
      logic     cycle_end;
      logic     cycle_ok;
      logic     fault_event;
      logic     batch_done;
      logic     batch_ok;
      logic     channel_valid;
      logic     battery_lost;
      fios_xy_s arm_xy;
   } fios_core_s;
   typedef struct packed {
      logic ready;
      logic busy;
      logic fault;
      logic cycle_done;
      logic judge_pass;
      logic judge_fail;
      logic batch_pass;
      logic batch_fail;
   } fios_stat_s;
endpackage

/* File: fios_plc_model.sv */
// Line controller model driving the discrete PLC inputs of the I/O status block
`timescale 1ns/1ns
`default_nettype none
module fios_plc_model #(
   parameter int HOLD_CYC = 20
) (
   input  wire logic              clock,
   input  wire logic              ready,
   output var fios_pkg::fios_pins_s pins
);
   localparam int START_BIT = 8;

   initial begin
      pins = '0;
   end

   // ************************************************************
   // Request tasks, called from the testbench
   // ************************************************************
   task automatic level(input int b, input logic v);
      @(posedge clock);
      pins[b] <= v;
   endtask

   task automatic sel(input logic [5:0] v);
      @(posedge clock);
      pins.pos_sel <= v;
   endtask

   // Start only goes out while ready is seen high
   task automatic pulse(input int b);
      if (b != START_BIT || ready === 1'b1) begin
         @(posedge clock);
         pins[b] <= 1'b1;
         repeat (HOLD_CYC + 5) @(posedge clock);
         pins[b] <= 1'b0;
         repeat (8) @(posedge clock);
      end
   endtask
endmodule // fios_plc_model
`default_nettype wire

/* File: fios_top.sv */
// Discrete I/O status, teaching and judgement logic of the fastening controller
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "fios_map.svh"
module fios_top #(
   parameter int CYC_PER_MS = `FIOS_CLK_HZ / `FIOS_MS_DIV,
   parameter int IN_HOLD_CYC = `FIOS_IN_HOLD_MS * CYC_PER_MS + 1,
   parameter int POS_N = 64
) (
   input  wire logic                 clock,
   input  wire logic                 sys_rst,
   input  wire fios_pkg::fios_pins_s pins,
   input  wire fios_pkg::fios_core_s core,
   input  wire logic [7:0]           bus_addr,
   input  wire logic [31:0]          bus_wdata,
   input  wire logic                 bus_wr,
   input  wire logic                 bus_rd,
   output logic      [31:0]          bus_rdata,
   output fios_pkg::fios_stat_s      stat,
   output fios_pkg::fios_teach_e     teach_mode,
   output fios_pkg::fios_xy_s        origin_xy,
   output logic                      irq
);
   localparam int IW = $clog2(POS_N);

   if (POS_N != 64 || CYC_PER_MS < 1) begin : g_chk
      $error("fios_top: bad parameters");
   end

   function automatic logic pos_valid(input logic [5:0] sel);
      return sel != 6'h00;
   endfunction

   // ************************************************************
   // Inputs
   // ************************************************************
   fios_pkg::fios_pins_s lvl;
   fios_pkg::fios_pins_s pls;

   fios_in_qual #(
      .WIDTH    ($bits(fios_pkg::fios_pins_s)),
      .HOLD_CYC (IN_HOLD_CYC)
   ) u_qual (
      .clock   (clock),
      .sys_rst (sys_rst),
      .pin_in  (pins),
      .level   (lvl),
      .pulse   (pls)
   );

   logic clr_judge;
   assign clr_judge = pls.start | pls.resume | pls.reset_in;

   // ************************************************************
   // Teaching mode
   // ************************************************************
   fios_pkg::fios_teach_e teach_next;
   logic                  teach_exit;
   logic [5:0]            all_idx_reg;
   logic [5:0]            sel_idx;
   logic                  sel_ok;
   logic                  cap_hit;
   logic                  commit_hit;

   always_comb begin
      teach_next = teach_mode;
      case (teach_mode)
         fios_pkg::T_IDLE: begin
            if (core.trace_job_en && lvl.teach_all) begin
               teach_next = fios_pkg::T_ALL;
            end else if (core.trace_job_en && lvl.teach_point &&
                         !core.tool_rotating && !core.panel_active) begin
               teach_next = fios_pkg::T_POINT;
            end
         end
         fios_pkg::T_ALL: begin
            if (!lvl.teach_all) teach_next = fios_pkg::T_IDLE;
         end
         fios_pkg::T_POINT: begin
            if (!lvl.teach_point) teach_next = fios_pkg::T_IDLE;
         end
         default: teach_next = fios_pkg::T_IDLE;
      endcase
   end

   assign teach_exit = (teach_mode != fios_pkg::T_IDLE) &&
                       (teach_next == fios_pkg::T_IDLE);
   assign sel_idx    = (teach_mode == fios_pkg::T_ALL) ? all_idx_reg : lvl.pos_sel;
   assign sel_ok     = pos_valid(sel_idx);
   assign cap_hit    = (teach_mode != fios_pkg::T_IDLE) && pls.capture && sel_ok;
   assign commit_hit = (teach_mode != fios_pkg::T_IDLE) && pls.commit;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         teach_mode <= fios_pkg::T_IDLE;
      end else begin
         teach_mode <= teach_next;
      end
   end

   // Walk every position in turn during teach-all
   always_ff @(posedge clock) begin
      if (sys_rst || teach_mode != fios_pkg::T_ALL) begin
         all_idx_reg <= 6'h01;
      end else if (pls.capture && all_idx_reg != 6'h3F) begin
         all_idx_reg <= all_idx_reg + 6'h01;
      end
   end

   // ************************************************************
   // Position lists
   // ************************************************************
   fios_pkg::fios_xy_s pend_xy [POS_N];
   fios_pkg::fios_xy_s list_xy [POS_N];
   logic [POS_N-1:0]   pend_vld;
   logic [POS_N-1:0]   list_vld;

   always_ff @(posedge clock) begin
      if (cap_hit) begin
         pend_xy[sel_idx] <= core.arm_xy;
      end
      if (commit_hit) begin
         for (int i = 0; i < POS_N; i++) begin
            if (pend_vld[i]) list_xy[i] <= pend_xy[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pend_vld <= '0;
      end else if (commit_hit || teach_exit) begin
         pend_vld <= '0;
      end else if (cap_hit) begin
         pend_vld[sel_idx] <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         list_vld <= '0;
      end else if (commit_hit) begin
         list_vld <= list_vld | pend_vld;
      end
   end

   // Origin offset held as battery-backed data
   always_ff @(posedge clock) begin
      if (sys_rst || core.battery_lost) begin
         origin_xy <= '0;
      end else if (core.trace_job_en && pls.zero_set) begin
         origin_xy <= core.arm_xy;
      end
   end

   // ************************************************************
   // Status outputs
   // ************************************************************
   logic        fault_next;
   logic        style_reg;
   logic [15:0] pulse_ms_reg;
   logic [31:0] pulse_len;
   logic [31:0] jcnt_reg;
   logic [31:0] bcnt_reg;

   assign fault_next = core.fault_event ||
                       (stat.fault && !pls.resume && !pls.reset_in);
   assign pulse_len  = 32'(pulse_ms_reg * CYC_PER_MS);

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat.fault <= 1'b0;
         stat.ready <= 1'b1;
         stat.busy  <= 1'b0;
      end else begin
         stat.fault <= fault_next;
         stat.ready <= !fault_next && core.channel_valid;
         stat.busy  <= core.cycle_active;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat.cycle_done <= 1'b0;
      end else if (core.cycle_end || (core.fault_event && stat.busy)) begin
         stat.cycle_done <= 1'b1;
      end else if (clr_judge) begin
         stat.cycle_done <= 1'b0;
      end
   end

   // Cycle judgement: set beats clear, pulse style times out
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat.judge_pass <= 1'b0;
         stat.judge_fail <= 1'b0;
         jcnt_reg        <= '0;
      end else if (core.cycle_end) begin
         stat.judge_pass <= core.cycle_ok;
         stat.judge_fail <= !core.cycle_ok;
         jcnt_reg        <= pulse_len;
      end else if (clr_judge ||
                   (style_reg && jcnt_reg <= 32'h0000_0001)) begin
         stat.judge_pass <= 1'b0;
         stat.judge_fail <= 1'b0;
         jcnt_reg        <= '0;
      end else if (jcnt_reg != '0) begin
         jcnt_reg <= jcnt_reg - 32'h0000_0001;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat.batch_pass <= 1'b0;
         stat.batch_fail <= 1'b0;
         bcnt_reg        <= '0;
      end else if (core.batch_done) begin
         stat.batch_pass <= core.batch_ok;
         stat.batch_fail <= !core.batch_ok;
         bcnt_reg        <= pulse_len;
      end else if (clr_judge ||
                   (style_reg && bcnt_reg <= 32'h0000_0001)) begin
         stat.batch_pass <= 1'b0;
         stat.batch_fail <= 1'b0;
         bcnt_reg        <= '0;
      end else if (bcnt_reg != '0) begin
         bcnt_reg <= bcnt_reg - 32'h0000_0001;
      end
   end

   // ************************************************************
   // Register port and interrupt
   // ************************************************************
   logic [`FIOS_EV_W-1:0] sts_reg;
   logic [`FIOS_EV_W-1:0] mask_reg;
   logic [`FIOS_EV_W-1:0] ev;
   logic [IW-1:0]         list_idx_reg;
   logic                  sts_rd;

   assign ev[`FIOS_EV_FAULT]  = core.fault_event;
   assign ev[`FIOS_EV_CYCLE]  = core.cycle_end;
   assign ev[`FIOS_EV_BATCH]  = core.batch_done;
   assign ev[`FIOS_EV_COMMIT] = commit_hit;
   assign sts_rd = bus_rd && bus_addr == `FIOS_OFS_STATUS;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         style_reg    <= 1'b0;
         pulse_ms_reg <= `FIOS_RST_PULSE_MS;
      end else if (bus_wr && bus_addr == `FIOS_OFS_CTRL) begin
         style_reg    <= bus_wdata[`FIOS_CTRL_STYLE_BIT];
         pulse_ms_reg <= bus_wdata[`FIOS_CTRL_MS_MSB:`FIOS_CTRL_MS_LSB];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         mask_reg     <= `FIOS_RST_MASK;
         list_idx_reg <= '0;
      end else if (bus_wr) begin
         if (bus_addr == `FIOS_OFS_MASK) mask_reg <= bus_wdata[`FIOS_EV_W-1:0];
         if (bus_addr == `FIOS_OFS_LIST_IDX) list_idx_reg <= bus_wdata[IW-1:0];
      end
   end

   // Read clears, a same-cycle event survives
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sts_reg <= '0;
         irq     <= 1'b0;
      end else begin
         sts_reg <= (sts_rd ? '0 : sts_reg) | ev;
         irq     <= |(((sts_rd ? '0 : sts_reg) | ev) & mask_reg);
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || !bus_rd) begin
         bus_rdata <= '0;
      end else begin
         case (bus_addr)
            `FIOS_OFS_CTRL:     bus_rdata <= {pulse_ms_reg, 15'h0000, style_reg};
            `FIOS_OFS_STATUS:   bus_rdata <= {28'h0000000, sts_reg};
            `FIOS_OFS_MASK:     bus_rdata <= {28'h0000000, mask_reg};
            `FIOS_OFS_STATE:    bus_rdata <= {22'h000000, teach_mode, stat};
            `FIOS_OFS_LIST_IDX: bus_rdata <= {list_vld[list_idx_reg], 25'h0000000,
                                              list_idx_reg};
            `FIOS_OFS_LIST_XY:  bus_rdata <= list_xy[list_idx_reg];
            `FIOS_OFS_ORIGIN:   bus_rdata <= origin_xy;
            default:            bus_rdata <= '0;
         endcase
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_teaching;
      teach_mode != fios_pkg::T_IDLE;
   endsequence
   sequence s_exit_bare;
      s_teaching ##0 teach_exit && !commit_hit;
   endsequence

   chk_teach_all_entry: assert property (
      teach_mode == fios_pkg::T_IDLE && core.trace_job_en && lvl.teach_all
      |=> teach_mode == fios_pkg::T_ALL)
      else $error("teach-all not entered");
   chk_point_exit: assert property (
      teach_mode == fios_pkg::T_POINT && !lvl.teach_point
      |=> teach_mode == fios_pkg::T_IDLE)
      else $error("teach-point not left");
   chk_point_gate: assert property (
      teach_mode == fios_pkg::T_IDLE && (core.tool_rotating || core.panel_active)
      |=> teach_mode != fios_pkg::T_POINT)
      else $error("teach-point entered while busy");
   chk_capture_store: assert property (
      cap_hit && !commit_hit && !teach_exit
      |=> pend_vld[$past(sel_idx)] && pend_xy[$past(sel_idx)] == $past(core.arm_xy))
      else $error("capture not stored");
   chk_discard_list: assert property (
      s_exit_bare |=> pend_vld == '0 && $stable(list_vld))
      else $error("pending list not discarded");
   chk_zero_origin: assert property (
      core.trace_job_en && pls.zero_set && !core.battery_lost
      |=> origin_xy == $past(core.arm_xy))
      else $error("origin not taken");
   chk_sel_zero: assert property (
      teach_mode == fios_pkg::T_POINT && lvl.pos_sel == 6'h00
      |-> !cap_hit)
      else $error("position zero accepted");
   chk_ready_fault: assert property (
      core.fault_event || !core.channel_valid |=> !stat.ready)
      else $error("ready during fault");
   chk_busy_track: assert property (
      stat.busy == $past(core.cycle_active))
      else $error("busy mismatch");
   chk_fault_hold: assert property (
      stat.fault && !pls.resume && !pls.reset_in |=> stat.fault)
      else $error("fault dropped early");
   chk_done_set: assert property (
      core.cycle_end |=> stat.cycle_done ##0 (stat.judge_pass != stat.judge_fail))
      else $error("cycle end not reported");
   chk_judge_once: assert property (
      !(stat.judge_pass && stat.judge_fail))
      else $error("both judgements active");
   chk_level_hold: assert property (
      !style_reg && stat.batch_pass && !clr_judge && !core.batch_done
      |=> stat.batch_pass)
      else $error("held batch output dropped");
   chk_reset_quiet: assert property (
      $past(sys_rst) |-> !stat.fault && !stat.busy && !stat.judge_pass &&
      pend_vld == '0)
      else $error("state after reset");
endmodule // fios_top
`default_nettype wire
